//--- verilog/sib_pkg.sv
// Constants for the serializer timing, self-test and watchdog register bank.
// Assumes a 250 MHz core clock standing in for the internal oscillator.
package sib_pkg;

   // Core clock period; all cycle counts derive from it.
   localparam int CLK_PERIOD_NS = 4;

   // Register offsets on the register-access I2C port.
   localparam logic [7:0] OFS_I2C_PIN_TIMING   = 8'h10;
   localparam logic [7:0] OFS_SCL_HIGH_WIDTH   = 8'h11;
   localparam logic [7:0] OFS_SCL_LOW_WIDTH    = 8'h12;
   localparam logic [7:0] OFS_GENERAL_PURPOSE  = 8'h13;
   localparam logic [7:0] OFS_SELF_TEST_CTRL   = 8'h14;
   localparam logic [7:0] OFS_LINK_WDOG_CTRL   = 8'h1E;
   localparam logic [7:0] OFS_SELF_TEST_CRC    = 8'h2A;

   // Field positions.
   localparam int HOLD_MSB     = 6;
   localparam int HOLD_LSB     = 4;
   localparam int FILT_MSB     = 3;
   localparam int FILT_LSB     = 0;
   localparam int CLKSRC_MSB   = 2;
   localparam int CLKSRC_LSB   = 1;
   localparam int BIST_BIT     = 0;
   localparam int WDTO_MSB     = 7;
   localparam int WDTO_LSB     = 1;
   localparam int WDDIS_BIT    = 0;

   // Reset values and the CRC error count limit.
   localparam logic [2:0] RST_HOLD     = 3'h1;
   localparam logic [3:0] RST_FILT     = 4'h7;
   localparam logic [7:0] RST_SCL_HIGH = 8'h82;
   localparam logic [7:0] RST_SCL_LOW  = 8'h82;
   localparam logic [6:0] RST_WD_TO    = 7'h7F;
   localparam logic [7:0] CRC_MAX      = 8'hFF;

   // Timing units; a unit step is a least time, the glitch step a longest one.
   localparam int HOLD_STEP_NS = 50;
   localparam int FILT_STEP_NS = 10;
   localparam int WDOG_STEP_NS = 2000000;
   localparam int CYC_50NS     = (HOLD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_10NS_RAW = FILT_STEP_NS / CLK_PERIOD_NS;
   localparam int CYC_10NS     = (CYC_10NS_RAW < 1) ? 1 : CYC_10NS_RAW;
   localparam int WDOG_STEP_CYC = WDOG_STEP_NS / CLK_PERIOD_NS;

   // Oscillator frequency word width (kHz).
   localparam int FREQ_W = 16;

   // Slave transfer states, Gray coded along the usual path except the ACK to RD and RACK to IDLE steps.
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ACK  = 3'h3,
      ST_WR   = 3'h2,
      ST_RD   = 3'h6,
      ST_RACK = 3'h7
   } sib_state_type;

endpackage

//--- verilog/sib_glitch_filter.sv
// Two-flop synchroniser followed by a programmable glitch filter.
// Assumes the pin is asynchronous to clk and idles high.
`timescale 1ns/1ns
`default_nettype none

module sib_glitch_filter (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       reset,
   // Pin and setting.
   input  wire logic       pin_in,
   input  wire logic [3:0] depth,
   // Filtered level.
   output logic            filt_out
);

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       lvl;
      logic [5:0] cnt;
   } sib_filt_type;

   sib_filt_type q;
   sib_filt_type n;
   logic [5:0]   limit;

   assign limit    = 6'(int'(depth) * sib_pkg::CYC_10NS);
   assign filt_out = q.lvl;

   // glitch rejection
   // A change is adopted only once it has outlasted the programmed width.
   always_comb begin
      n    = q;
      n.s1 = pin_in;
      n.s2 = q.s1;
      if (q.s2 == q.lvl) begin
         n.cnt = 6'h00;
      end else if (q.cnt >= limit) begin
         n.lvl = q.s2;
         n.cnt = 6'h00;
      end else begin
         n.cnt = q.cnt + 6'h01;
      end
   end

   // Idle-high reset keeps a false start from being seen after reset.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q     <= '0;
         q.s1  <= 1'b1;
         q.s2  <= 1'b1;
         q.lvl <= 1'b1;
      end else begin
         q <= n;
      end
   end

   a_filter_follow: assert property (
      @(posedge clk) disable iff (reset)
      (q.lvl != $past(q.lvl)) |-> ($past(q.s2) == q.lvl && $past(q.cnt) >= $past(limit)))
      else $error("Filter output changed before the glitch width expired.");

endmodule

`default_nettype wire

//--- verilog/sib_regs.sv
// Register bank for pin timing, general bits, self test and link watchdog.
// Assumes registers are reached over an open-drain I2C slave port and that
// cc_busy and crc_err come from logic on clk; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none

// Function
// - SDA hold field bits 6:4, 50 ns steps, reset 1.
// - glitch filter width bits 3:0, 10 ns steps, reset 7.
// - SCL high width register for local master, 50 ns units, reset 0x82.
// - SCL low width register for local master, 50 ns units, reset 0x82.
// - slave reuses SCL low width as data setup before releasing SCL.
// - timing counts oscillator cycles; defaults meet I2C minimum at fast oscillator.
// - clock source bits 2:1 select oscillator frequency for forward frames.
// - self-test enable bit 0, reset zero.
// - watchdog aborts control transactions exceeding the timeout.
// - watchdog timeout bits 7:1 in 2 ms steps, reset 0x7F.
// - watchdog disable bit 0 stops the watchdog, reset zero.
// - read-only CRC error count of back channel during self test.
module sib_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary default bus address.
   parameter int WDOG_STEP_CYC = sib_pkg::WDOG_STEP_CYC,
   parameter logic [3:0][sib_pkg::FREQ_W-1:0] OSC_FREQ_KHZ =
      {16'h61A8, 16'h5DC0, 16'h55F0, 16'h4E20}
) (
   // Clock and reset.
   input  wire logic                      clk,
   input  wire logic                      reset,
   // Register-access I2C slave pins.
   input  wire logic                      scl_i,
   output logic                           scl_o,
   output logic                           scl_oe_n,
   input  wire logic                      sda_i,
   output logic                           sda_o,
   output logic                           sda_oe_n,
   // Local I2C master clock.
   input  wire logic                      mst_run,
   output logic                           mst_scl_o,
   output logic                           mst_scl_oe_n,
   // Control link transaction supervision.
   input  wire logic                      cc_busy,
   output logic                           cc_abort,
   // Self test.
   input  wire logic                      crc_err,
   output logic                           bist_en,
   output logic [1:0]                     clk_src,
   output logic [sib_pkg::FREQ_W-1:0]     osc_freq_khz,
   // General-purpose bits.
   output logic [7:0]                     general_purpose_bits
);

   localparam int PRE_W = $clog2(WDOG_STEP_CYC + 1);
   localparam int C50   = sib_pkg::CYC_50NS;

   typedef struct packed {
      sib_pkg::sib_state_type     st;
      logic [2:0]                 cnt;
      logic [7:0]                 shift;
      logic                       rw;
      logic                       first;
      logic [7:0]                 ptr;
      logic                       scl_prev;
      logic                       sda_v;
      logic [6:0]                 hold_cnt;
      logic [11:0]                str_cnt;
      logic                       sda_oe_n;
      logic                       scl_oe_n;
      logic                       pin_lo;
      logic [2:0]                 r_hold;
      logic [3:0]                 r_filt;
      logic [7:0]                 r_sclh;
      logic [7:0]                 r_scll;
      logic [7:0]                 r_gp;
      logic [1:0]                 r_clksrc;
      logic                       r_bist;
      logic [6:0]                 r_wd_to;
      logic                       r_wd_dis;
      logic [7:0]                 crc;
      logic                       mst_high;
      logic [11:0]                mst_cnt;
      logic                       mst_oe_n;
      logic [PRE_W-1:0]           wd_pre;
      logic [6:0]                 wd_ticks;
      logic                       wd_abort;
      logic [sib_pkg::FREQ_W-1:0] osc_freq;
   } sib_regs_type;

   sib_regs_type q;
   sib_regs_type n;
   logic         scl_f;
   logic         sda_f;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_c;
   logic         stop_c;

   // Both pins pass the synchroniser and the programmable filter.
   sib_glitch_filter u_scl_filt (
      .clk      (clk),
      .reset    (reset),
      .pin_in   (scl_i),
      .depth    (q.r_filt),
      .filt_out (scl_f)
   );

   sib_glitch_filter u_sda_filt (
      .clk      (clk),
      .reset    (reset),
      .pin_in   (sda_i),
      .depth    (q.r_filt),
      .filt_out (sda_f)
   );

   // Bus events; SDA is only trusted once the hold window has closed.
   assign scl_rise = scl_f & ~q.scl_prev;
   assign scl_fall = ~scl_f & q.scl_prev;
   assign start_c  = scl_f & q.scl_prev & (q.hold_cnt == 7'h00) & q.sda_v & ~sda_f;
   assign stop_c   = scl_f & q.scl_prev & (q.hold_cnt == 7'h00) & ~q.sda_v & sda_f;

   // Read mux; unmapped offsets and reserved bits read as zero.
   function automatic logic [7:0] rd_reg(input logic [7:0] a, input sib_regs_type s);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         sib_pkg::OFS_I2C_PIN_TIMING:  v = {1'b0, s.r_hold, s.r_filt};
         sib_pkg::OFS_SCL_HIGH_WIDTH:  v = s.r_sclh;
         sib_pkg::OFS_SCL_LOW_WIDTH:   v = s.r_scll;
         sib_pkg::OFS_GENERAL_PURPOSE: v = s.r_gp;
         sib_pkg::OFS_SELF_TEST_CTRL:  v = {5'h00, s.r_clksrc, s.r_bist};
         sib_pkg::OFS_LINK_WDOG_CTRL:  v = {s.r_wd_to, s.r_wd_dis};
         sib_pkg::OFS_SELF_TEST_CRC:   v = s.crc;
         default:                      v = 8'h00;
      endcase
      return v;
   endfunction

   // Phase length in cycles for a width given in 50 ns units.
   function automatic logic [11:0] phase_len(input logic [7:0] w);
      return (w == 8'h00) ? 12'h000 : 12'(int'(w) * C50 - 1);
   endfunction

   // Next-state logic for the whole bank.
   always_comb begin
      n          = q;
      n.pin_lo   = 1'b0;
      n.scl_prev = scl_f;
      n.wd_abort = 1'b0;

      if (scl_fall) begin
         n.hold_cnt = 7'(int'(q.r_hold) * C50);
      end else if (q.hold_cnt != 7'h00) begin
         n.hold_cnt = q.hold_cnt - 7'h01;
      end else begin
         n.sda_v = sda_f;
      end

      // Stretch countdown; SCL is released when it runs out.
      if (q.str_cnt != 12'h000) begin
         n.str_cnt = q.str_cnt - 12'h001;
      end else begin
         n.scl_oe_n = 1'b1;
      end

      // Slave transfer machine: start and stop win over bit events.
      if (start_c) begin
         n.st       = sib_pkg::ST_ADDR;
         n.cnt      = 3'h0;
         n.first    = 1'b1;
         n.sda_oe_n = 1'b1;
      end else if (stop_c) begin
         n.st       = sib_pkg::ST_IDLE;
         n.sda_oe_n = 1'b1;
      end else if (scl_fall) begin
         if (q.st == sib_pkg::ST_ACK || q.st == sib_pkg::ST_RD) begin
            n.sda_oe_n = (q.st == sib_pkg::ST_RD) ? q.shift[7] : 1'b0;
            n.scl_oe_n = 1'b0;
            n.str_cnt  = 12'(int'(q.r_scll) * C50);
         end else begin
            n.sda_oe_n = 1'b1;
         end
      end else if (scl_rise) begin
         unique case (q.st)
            sib_pkg::ST_ADDR: begin
               n.shift = {q.shift[6:0], q.sda_v};
               n.cnt   = q.cnt + 3'h1;
               if (q.cnt == 3'h7) begin
                  n.rw = q.sda_v;
                  n.st = (q.shift[6:0] == DEV_ADDR) ? sib_pkg::ST_ACK : sib_pkg::ST_IDLE;
               end
            end
            sib_pkg::ST_WR: begin
               n.shift = {q.shift[6:0], q.sda_v};
               n.cnt   = q.cnt + 3'h1;
               if (q.cnt == 3'h7) begin
                  n.st = sib_pkg::ST_ACK;
                  if (q.first) begin
                     n.ptr   = {q.shift[6:0], q.sda_v};
                     n.first = 1'b0;
                  end else begin
                     n.ptr = q.ptr + 8'h01;
                     unique case (q.ptr)
                        sib_pkg::OFS_I2C_PIN_TIMING: begin
                           n.r_hold = q.shift[sib_pkg::HOLD_MSB-1:sib_pkg::HOLD_LSB-1];
                           n.r_filt = {q.shift[sib_pkg::FILT_MSB-1:sib_pkg::FILT_LSB], q.sda_v};
                        end
                        sib_pkg::OFS_SCL_HIGH_WIDTH:  n.r_sclh = {q.shift[6:0], q.sda_v};
                        sib_pkg::OFS_SCL_LOW_WIDTH:   n.r_scll = {q.shift[6:0], q.sda_v};
                        sib_pkg::OFS_GENERAL_PURPOSE: n.r_gp   = {q.shift[6:0], q.sda_v};
                        sib_pkg::OFS_SELF_TEST_CTRL: begin
                           n.r_clksrc = q.shift[sib_pkg::CLKSRC_MSB-1:sib_pkg::CLKSRC_LSB-1];
                           n.r_bist   = q.sda_v;
                        end
                        sib_pkg::OFS_LINK_WDOG_CTRL: begin
                           n.r_wd_to  = q.shift[sib_pkg::WDTO_MSB-1:sib_pkg::WDTO_LSB-1];
                           n.r_wd_dis = q.sda_v;
                        end
                        default: ;
                     endcase
                  end
               end
            end
            sib_pkg::ST_ACK: begin
               n.cnt = 3'h0;
               if (q.rw) begin
                  n.st    = sib_pkg::ST_RD;
                  n.shift = rd_reg(q.ptr, q);
                  n.ptr   = q.ptr + 8'h01;
               end else begin
                  n.st = sib_pkg::ST_WR;
               end
            end
            sib_pkg::ST_RD: begin
               n.shift = {q.shift[6:0], 1'b1};
               n.cnt   = q.cnt + 3'h1;
               if (q.cnt == 3'h7) begin
                  n.st = sib_pkg::ST_RACK;
               end
            end
            sib_pkg::ST_RACK: begin
               n.cnt = 3'h0;
               if (q.sda_v) begin
                  n.st = sib_pkg::ST_IDLE; // Master declined more data.
               end else begin
                  n.st    = sib_pkg::ST_RD;
                  n.shift = rd_reg(q.ptr, q);
                  n.ptr   = q.ptr + 8'h01;
               end
            end
            sib_pkg::ST_IDLE: ;
            default: n.st = sib_pkg::ST_IDLE;
         endcase
      end

      if (n.r_bist && !q.r_bist) begin
         n.crc = 8'h00;
      end else if (q.r_bist && crc_err && q.crc != sib_pkg::CRC_MAX) begin
         n.crc = q.crc + 8'h01;
      end

      if (!cc_busy || q.r_wd_dis) begin
         n.wd_pre   = '0;
         n.wd_ticks = 7'h00;
      end else if (q.wd_pre == PRE_W'(WDOG_STEP_CYC - 1)) begin
         n.wd_pre = '0;
         if (q.wd_ticks + 7'h01 >= q.r_wd_to) begin
            n.wd_abort = 1'b1;
            n.wd_ticks = 7'h00;
         end else begin
            n.wd_ticks = q.wd_ticks + 7'h01;
         end
      end else begin
         n.wd_pre = q.wd_pre + PRE_W'(1);
      end

      if (!mst_run) begin
         n.mst_high = 1'b1;
         n.mst_oe_n = 1'b1;
         n.mst_cnt  = phase_len(q.r_sclh);
      end else if (q.mst_cnt != 12'h000) begin
         n.mst_cnt = q.mst_cnt - 12'h001;
      end else if (q.mst_high) begin
         n.mst_high = 1'b0;
         n.mst_oe_n = 1'b0;
         n.mst_cnt  = phase_len(q.r_scll);
      end else begin
         n.mst_high = 1'b1;
         n.mst_oe_n = 1'b1;
         n.mst_cnt  = phase_len(q.r_sclh);
      end

      n.osc_freq = OSC_FREQ_KHZ[q.r_clksrc];
   end

   // State register; reset leaves both pins released and defaults loaded.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q          <= '0;
         q.st       <= sib_pkg::ST_IDLE;
         q.scl_prev <= 1'b1;
         q.sda_v    <= 1'b1;
         q.sda_oe_n <= 1'b1;
         q.scl_oe_n <= 1'b1;
         q.r_hold   <= sib_pkg::RST_HOLD;
         q.r_filt   <= sib_pkg::RST_FILT;
         q.r_sclh   <= sib_pkg::RST_SCL_HIGH;
         q.r_scll   <= sib_pkg::RST_SCL_LOW;
         q.r_wd_to  <= sib_pkg::RST_WD_TO;
         q.mst_high <= 1'b1;
         q.mst_oe_n <= 1'b1;
         q.osc_freq <= OSC_FREQ_KHZ[0];
      end else begin
         q <= n;
      end
   end

   // Outputs are plain register fields.
   assign scl_o                = q.pin_lo;
   assign sda_o                = q.pin_lo;
   assign scl_oe_n             = q.scl_oe_n;
   assign sda_oe_n             = q.sda_oe_n;
   assign mst_scl_o            = q.pin_lo;
   assign mst_scl_oe_n         = q.mst_oe_n;
   assign cc_abort             = q.wd_abort;
   assign bist_en              = q.r_bist;
   assign clk_src              = q.r_clksrc;
   assign osc_freq_khz         = q.osc_freq;
   assign general_purpose_bits = q.r_gp;

   a_ack_stretch: assert property (
      @(posedge clk) disable iff (reset)
      (scl_fall && !start_c && !stop_c && q.st == sib_pkg::ST_ACK)
         |=> (!sda_oe_n && !scl_oe_n && q.str_cnt == 12'(int'($past(q.r_scll)) * C50)))
      else $error("Acknowledge did not stretch SCL by the low width.");

   a_stretch_hold: assert property (
      @(posedge clk) disable iff (reset)
      (q.str_cnt != 12'h000) |=> !scl_oe_n)
      else $error("SCL released while the setup interval was still running.");

   a_sda_hold: assert property (
      @(posedge clk) disable iff (reset)
      (q.hold_cnt != 7'h00) |=> (q.sda_v == $past(q.sda_v)))
      else $error("SDA view changed inside the hold window.");

   a_crc_sat: assert property (
      @(posedge clk) disable iff (reset)
      (q.crc == sib_pkg::CRC_MAX && q.r_bist && crc_err) ##1 q.r_bist
         |-> (q.crc == sib_pkg::CRC_MAX))
      else $error("CRC error count wrapped past its maximum.");

   a_crc_clear: assert property (
      @(posedge clk) disable iff (reset)
      $rose(q.r_bist) |-> (q.crc == 8'h00))
      else $error("CRC error count not cleared on self-test enable.");

   a_crc_idle: assert property (
      @(posedge clk) disable iff (reset)
      (!q.r_bist ##1 !q.r_bist) |-> $stable(q.crc))
      else $error("CRC error count moved outside self test.");

   a_wdog_off: assert property (
      @(posedge clk) disable iff (reset)
      q.r_wd_dis |=> !cc_abort)
      else $error("Disabled watchdog raised an abort.");

   a_wdog_idle: assert property (
      @(posedge clk) disable iff (reset)
      !cc_busy |=> (!cc_abort && q.wd_ticks == 7'h00))
      else $error("Watchdog ran without a transaction in progress.");

   a_mst_release: assert property (
      @(posedge clk) disable iff (reset)
      !mst_run |=> (mst_scl_oe_n && q.mst_high))
      else $error("Master SCL driven while the master is idle.");

   a_mst_phase: assert property (
      @(posedge clk) disable iff (reset)
      (mst_run && q.mst_cnt != 12'h000) |=> $stable(mst_scl_oe_n))
      else $error("Master SCL toggled before its phase width ran out.");

   a_osc_map: assert property (
      @(posedge clk) disable iff (reset)
      1'b1 |=> (osc_freq_khz == OSC_FREQ_KHZ[$past(q.r_clksrc)]))
      else $error("Oscillator frequency does not follow the clock source.");

endmodule

`default_nettype wire

//--- tb/sib_i2c_host.sv
// Behavioural I2C master standing on the register port of the bank.
// Assumes the bench resolves the open-drain wires from every enable.
`timescale 1ns/1ns
`default_nettype none
module sib_i2c_host (
   // Resolved wire levels.
   input  wire logic scl_w,
   input  wire logic sda_w,
   // Host drives, high is released; stuck flags an endless stretch.
   output logic      scl_d,
   output logic      sda_d,
   output logic      stuck
);
   // Idle bus with both lines released.
   initial begin
      scl_d = 1'b1;
      sda_d = 1'b1;
      stuck = 1'b0;
   end
   // One bit; data moves early in the low phase so the hold window hides it.
   task automatic bit_cell(input logic b, output logic s);
      int n;
      scl_d = 1'b0;
      #10 sda_d = b;
      #80 scl_d = 1'b1;
      n = 0;
      while (scl_w !== 1'b1 && n < 5000) begin
         #4 n++;
      end
      if (n == 5000)
         stuck = 1'b1;
      #70 s = sda_w;
   endtask
   // Eight bits MSB first, then the acknowledge cell.
   task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_cell(d[i], q[i]);
      bit_cell(last, ack);
   endtask
   // Start or repeated start; a long low phase lets the slave let go of SDA.
   task automatic start();
      scl_d = 1'b0;
      #10 sda_d = 1'b1;
      #170 scl_d = 1'b1;
      #80 sda_d = 1'b0;
      #80;
   endtask
   // Stop, then the bus rests.
   task automatic stop();
      scl_d = 1'b0;
      #10 sda_d = 1'b0;
      #90 scl_d = 1'b1;
      #80 sda_d = 1'b1;
      #200;
   endtask
   // A lone low pulse on SDA of the given width, to probe the glitch filter.
   task automatic glitch(input int w);
      sda_d = 1'b0;
      #w sda_d = 1'b1;
   endtask
endmodule
`default_nettype wire

//--- tb/sib_regs_bench.sv
// Self-checking bench for the pin timing, self-test and watchdog bank.
// Assumes the host model on the register port; pins are resolved here.
`timescale 1ns/1ns
`default_nettype none
module sib_regs_bench;
   localparam int STEP = 4;
   localparam logic [6:0] ADR = 7'h2A; // Arbitrary bus address.
   localparam logic [3:0][15:0] FREQ = {16'h0D04, 16'h0C03, 16'h0B02, 16'h0A01};
   // Rows: offset, value written, value read back.
   // timeout row never zero
   localparam logic [23:0] ROWS [8] = '{24'h120101, 24'h108303, 24'h110505, 24'h13A5A5,
      24'h14FD05, 24'h1E0404, 24'h2A5500, 24'h203300};
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        mst_run = 1'b0;
   logic        cc_busy = 1'b0;
   logic        crc_err = 1'b0;
   logic        scl_o, scl_oe_n, sda_o, sda_oe_n, mst_scl_o, mst_scl_oe_n;
   logic        cc_abort, bist_en, scl_d, sda_d, stuck, a, lo;
   logic [1:0]  clk_src;
   logic [15:0] osc;
   logic [7:0]  gpb, q;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          run = 0;
   int          last_run = 0;
   int          m;
   // Open-drain wires are low when any party pulls.
   wire logic   scl_w = scl_d & (scl_oe_n | scl_o);
   wire logic   sda_w = sda_d & (sda_oe_n | sda_o);

   sib_regs #(.DEV_ADDR(ADR), .WDOG_STEP_CYC(STEP), .OSC_FREQ_KHZ(FREQ)) u_sib_regs (
      .clk(clk), .reset(reset), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .mst_run(mst_run),
      .mst_scl_o(mst_scl_o), .mst_scl_oe_n(mst_scl_oe_n), .cc_busy(cc_busy),
      .cc_abort(cc_abort), .crc_err(crc_err), .bist_en(bist_en), .clk_src(clk_src),
      .osc_freq_khz(osc), .general_purpose_bits(gpb));
   sib_i2c_host u_sib_i2c_host (.scl_w(scl_w), .sda_w(sda_w), .scl_d(scl_d),
      .sda_d(sda_d), .stuck(stuck));

   // Core clock.
   always #2 clk = ~clk;
   // Length of the latest SCL stretch in core cycles.
   always @(posedge clk) begin
      if (scl_oe_n === 1'b0) begin
         run++;
      end else if (run != 0) begin
         last_run = run;
         run = 0;
      end
   end
   // A host hung on a stretched SCL ends the run.
   always @(posedge stuck) begin
      error_cnt++;
      close_out();
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Counts taken on sampled edges may land one cycle either way.
   task automatic near(input int got, input int exp);
      n_compared++;
      if (got < exp - 1 || got > exp + 1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("Compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
      // Pin edges then land off both clock edges, so the synchroniser never races.
      @(negedge clk);
      #1;
      u_sib_i2c_host.start();
      u_sib_i2c_host.byte_x({ADR, 1'b0}, 1'b1, q, a);
      u_sib_i2c_host.byte_x(ofs, 1'b1, q, a);
      u_sib_i2c_host.byte_x(d, 1'b1, q, a);
      u_sib_i2c_host.stop();
      chk(a, 1'b0);
   endtask
   task automatic reg_rd(input logic [7:0] ofs, output logic [7:0] d);
      @(negedge clk);
      #1;
      u_sib_i2c_host.start();
      u_sib_i2c_host.byte_x({ADR, 1'b0}, 1'b1, q, a);
      u_sib_i2c_host.byte_x(ofs, 1'b1, q, a);
      u_sib_i2c_host.start();
      u_sib_i2c_host.byte_x({ADR, 1'b1}, 1'b1, q, a);
      u_sib_i2c_host.byte_x(8'hFF, 1'b1, d, a);
      u_sib_i2c_host.stop();
   endtask
   // Lowest filtered SDA level seen around an idle-bus pulse of the given width.
   task automatic pulse(input int w, output logic low);
      low = 1'b1;
      @(negedge clk);
      #1;
      fork
         u_sib_i2c_host.glitch(w);
         repeat (24) @(negedge clk) low = low & u_sib_regs.u_sda_filt.filt_out;
      join
   endtask
   // Watchdog: hold busy until the abort pulse or the limit.
   task automatic wd(input int lim);
      m = 0;
      @(posedge clk) cc_busy <= 1'b1;
      while (cc_abort !== 1'b1 && m < lim) begin
         @(negedge clk);
         m++;
      end
      @(posedge clk) cc_busy <= 1'b0;
   endtask
   // Local master SCL: length of one phase at the given enable level.
   task automatic ph(input logic lvl);
      m = 0;
      while (mst_scl_oe_n === lvl && m < 4000) begin
         @(negedge clk);
         m++;
      end
   endtask
   task automatic mst(input int hi, input int lo);
      @(posedge clk) mst_run <= 1'b1;
      ph(1'b1);
      near(m, hi);
      ph(1'b0);
      near(m, lo);
      @(posedge clk) mst_run <= 1'b0;
   endtask

   // Reset values, table rows, then the awkward cases.
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk({gpb, 5'h0, clk_src, bist_en}, 16'h0000);
      chk(osc, FREQ[0]);
      #100;
      reg_rd(8'h10, q);
      chk(q, 8'h17);
      near(last_run, 16'h82 * 13 + 1);
      mst(1690, 1690);
      wd(2000);
      near(m, 127 * STEP + 2);
      foreach (ROWS[i]) begin
         reg_wr(ROWS[i][23:16], ROWS[i][15:8]);
         reg_rd(ROWS[i][23:16], q);
         chk(q, ROWS[i][7:0]);
      end
      near(last_run, 14);
      pulse(12, lo);
      chk(lo, 1'b1);
      pulse(60, lo);
      chk(lo, 1'b0);
      chk({gpb, 5'h0, clk_src, bist_en}, 16'hA505);
      mst(65, 13);
      wd(2000);
      near(m, 2 * STEP + 2);
      reg_wr(8'h1E, 8'h05);
      wd(40);
      chk(m, 40);
      for (int c = 0; c < 4; c++) begin
         reg_wr(8'h14, {5'h0, c[1:0], 1'b1});
         chk(osc, FREQ[c]);
      end
      repeat (260) begin
         @(posedge clk) crc_err <= 1'b1;
         @(posedge clk) crc_err <= 1'b0;
      end
      reg_rd(8'h2A, q);
      chk(q, 8'hFF);
      reg_wr(8'h14, 8'h00);
      reg_wr(8'h14, 8'h01);
      reg_rd(8'h2A, q);
      chk(q, 8'h00);
      @(posedge clk) reset <= 1'b1;
      @(negedge clk);
      chk({gpb, 5'h0, clk_src, bist_en}, 16'h0000);
      close_out();
   end
endmodule
`default_nettype wire
